// ===== common/spm_map.svh
`ifndef SPM_MAP_SVH
`define SPM_MAP_SVH
// Enable field of the status-routing register, bits 12 down to 7
`define SPM_EN_MSB          12
`define SPM_EN_LSB          7
`define SPM_EN_A_SELREF     12
`define SPM_EN_A_LOSS       11
`define SPM_EN_A_UNLOCK     10
`define SPM_EN_B_SELREF     9
`define SPM_EN_B_LOSS       8
`define SPM_EN_B_UNLOCK     7
// Secondary input enable bit in the input-control register
`define SPM_SEC_EN_BIT      5
// Interface select code for pin mode
`define SPM_IFSEL_PIN       2'h2
// Reference choice encodings
`define SPM_REF_PRIMARY     1'h0
`define SPM_REF_SECONDARY   1'h1
// Preset codes steering to the primary reference
`define SPM_PRESET_PRI_MAP  32'h9C_D0_00_00
`define SPM_RST_HEALTH      1'h0
// Reset value of the readable status bits
`define SPM_RST_STATUS      1'h0
// Two status pins, three routable events on each
`define SPM_PIN_COUNT       2
`define SPM_EVENTS_PER_PIN  3
`endif

// ===== common/spm_pkg.sv
`default_nettype none
package spm_pkg;
  typedef logic [1:0] spm_ifsel_t;   // Interface select code
  typedef logic [4:0] spm_preset_t;  // Pin-mode preset code
  typedef logic [5:0] spm_route_t;   // Routing enables, bit 5 maps to register bit 12
endpackage
`default_nettype wire

// ===== logic/spm_preset_rom.sv
`timescale 1ns/1ps
`default_nettype none
`include "spm_map.svh"
// Registered preset table: code in, reference choice out one cycle later
module spm_preset_rom (
  input  wire logic                 core_clk,
  input  wire logic                 sys_rst,
  input  wire spm_pkg::spm_preset_t presetCode,
  output var  logic                 refChoice
);
  import spm_pkg::*;
  localparam logic [31:0] PRI_MAP = `SPM_PRESET_PRI_MAP;  // One bit per preset, set means primary
  wire lookupPrimary;                                     // Table hit for the primary input
  wire next_refChoice;                                    // Decoded choice
  assign lookupPrimary  = PRI_MAP[presetCode];
  assign next_refChoice = lookupPrimary ? `SPM_REF_PRIMARY : `SPM_REF_SECONDARY;
  // Output register; reset picks the secondary as the common preset choice
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      refChoice <= `SPM_REF_SECONDARY;
    end else begin
      refChoice <= next_refChoice;
    end
  end
endmodule
`default_nettype wire

// ===== logic/spm_status_pin_mapper.sv
// Operation
// - Two status pins, six enables pick content
// - Selected-reference flag: primary 0, secondary 1
// - Reference-loss flag: present 0, lost 1
// - Secondary disabled forces loss flag high
// - Every event also readable as a status bit
// - Pin-mode preset code chooses primary or secondary
// - Several enables on a pin OR together
// - Unlock routed by bits 10/7; flag inverted
`timescale 1ns/1ps
`default_nettype none
`include "spm_map.svh"
module spm_status_pin_mapper (
  input  wire logic                 core_clk,
  input  wire logic                 sys_rst,
  input  wire spm_pkg::spm_route_t  routeEnable,
  input  wire logic                 secondaryEnable,
  input  wire spm_pkg::spm_ifsel_t  interfaceSelect,
  input  wire spm_pkg::spm_preset_t presetCode,
  input  wire logic                 regRefSelect,
  input  wire logic                 primaryPresent,
  input  wire logic                 secondaryPresent,
  input  wire logic                 pllLocked,
  output var  logic                 health_out_a,
  output var  logic                 health_out_b,
  output var  logic                 selRefStatus,
  output var  logic                 ref_loss_flag,
  output var  logic                 unlockStatus
);
  import spm_pkg::*;

  // Event sources before registering; selected-reference and loss are computed once and
  // shared by both pins and the status bits, while unlock is derived twice with opposite sense
  wire       pinMode;        // Interface select says pin mode
  wire       presetChoice;   // Registered choice from the preset table
  wire       activeSel;      // Reference actually driving the PLL
  wire       activePresent;  // Selected input shows activity
  wire       lossEvent;      // Loss event after the secondary-enable override
  wire       unlockEvent;    // Unlock as software reads it, 1 while unlocked
  wire       pinUnlockLevel; // Unlock as the pins show it, high while locked
  wire [2:0] eventVec;       // Pin-level events {selref, loss, lock level}
  wire [1:0] next_health;    // OR of enabled events, index 1 is pin A

  // Preset table lookup is registered, so a pin-mode choice lags one edge
  spm_preset_rom u_spm_preset_rom (
    .core_clk   (core_clk),
    .sys_rst    (sys_rst),
    .presetCode (presetCode),
    .refChoice  (presetChoice)
  );

  // Pin mode takes the table choice, serial modes take the register choice
  assign pinMode       = (interfaceSelect == `SPM_IFSEL_PIN);
  assign activeSel     = pinMode ? presetChoice : regRefSelect;
  // Secondary selected reads 1, primary reads 0
  assign activePresent = (activeSel == `SPM_REF_SECONDARY) ? secondaryPresent : primaryPresent;
  // With the secondary input off, the loss detector is not trustworthy, so
  // it is pinned high; software must enable it first to get a real reading
  assign lossEvent     = ~secondaryEnable | ~activePresent;
  // Flag and pin carry unlock with opposite sense: the flag reads 1 on
  // unlock, the pin stays high while locked and drops on unlock
  assign unlockEvent    = ~pllLocked;
  assign pinUnlockLevel = pllLocked;
  assign eventVec       = {activeSel, lossEvent, pinUnlockLevel};

  // One OR tree per pin; enable slice 5:3 is pin A, slice 2:0 is pin B.
  // Several enables on one pin are legal but make the pin ambiguous, so
  // software normally sets only one of the three
  genvar pin;
  generate
    for (pin = 0; pin < `SPM_PIN_COUNT; pin = pin + 1) begin : g_pin
      // Enables of this pin, lined up with the event bits
      wire [2:0] pinRoute;
      assign pinRoute = routeEnable[pin*`SPM_EVENTS_PER_PIN +: `SPM_EVENTS_PER_PIN];
      assign next_health[pin] = |(eventVec & pinRoute);
    end
  endgenerate

  // Registered pin and status outputs, all updated on the same edge so a
  // host comparing pin and status bit never sees them a cycle apart
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      // Quiet pins and clear status while the core is held
      health_out_a  <= `SPM_RST_HEALTH;
      health_out_b  <= `SPM_RST_HEALTH;
      selRefStatus  <= `SPM_RST_STATUS;
      ref_loss_flag <= `SPM_RST_STATUS;
      unlockStatus  <= `SPM_RST_STATUS;
    end else begin
      // Pins take the OR trees, index 1 is pin A
      health_out_a  <= next_health[1];
      health_out_b  <= next_health[0];
      selRefStatus  <= activeSel;
      ref_loss_flag <= lossEvent;
      // Flag reads 1 on unlock while the pin drives low on unlock
      unlockStatus  <= unlockEvent;
    end
  end

  // Checks
  property p_or_a;
    @(posedge core_clk) disable iff (sys_rst)
      (routeEnable[5:3] != 3'h0 && (eventVec & routeEnable[5:3]) != 3'h0) |=> health_out_a;
  endproperty
  a_or_a: assert property (p_or_a) else $error("pin A missed an enabled event");

  property p_off_b;
    @(posedge core_clk) disable iff (sys_rst)
      (routeEnable[2:0] == 3'h0) |=> !health_out_b;
  endproperty
  a_off_b: assert property (p_off_b) else $error("pin B high with no enables");

  property p_loss_forced;
    @(posedge core_clk) disable iff (sys_rst)
      !secondaryEnable |=> ref_loss_flag;
  endproperty
  a_loss_forced: assert property (p_loss_forced) else $error("loss flag not forced high");

  property p_loss_real;
    @(posedge core_clk) disable iff (sys_rst)
      (secondaryEnable && activePresent) |=> !ref_loss_flag;
  endproperty
  a_loss_real: assert property (p_loss_real) else $error("loss flag set with reference present");

  property p_selref;
    @(posedge core_clk) disable iff (sys_rst)
      (!pinMode) |=> (selRefStatus == $past(regRefSelect));
  endproperty
  a_selref: assert property (p_selref) else $error("selected-reference flag wrong");

  property p_unlock_polarity;
    @(posedge core_clk) disable iff (sys_rst)
      1'h1 |=> (unlockStatus != $past(pinUnlockLevel));
  endproperty
  a_unlock_polarity: assert property (p_unlock_polarity) else $error("unlock flag polarity wrong");

  sequence s_pin_preset_pri;
    pinMode && presetCode == 5'h14 ##1 pinMode;
  endsequence
  property p_preset;
    @(posedge core_clk) disable iff (sys_rst)
      s_pin_preset_pri |=> (selRefStatus == `SPM_REF_PRIMARY);
  endproperty
  a_preset: assert property (p_preset) else $error("preset 0x14 did not pick primary");

  property p_pin_b_unlock;
    @(posedge core_clk) disable iff (sys_rst)
      (routeEnable[2:0] == 3'h1 && !pllLocked) |=> (!health_out_b && unlockStatus);
  endproperty
  a_pin_b_unlock: assert property (p_pin_b_unlock) else $error("unlock not seen on pin B and flag");

  // Pin B mirror of the OR check: any enabled event must raise it
  property p_or_b;
    @(posedge core_clk) disable iff (sys_rst)
      ((eventVec & routeEnable[2:0]) != 3'h0) |=> health_out_b;
  endproperty
  a_or_b: assert property (p_or_b) else $error("pin B missed an enabled event");

  // An unused pin must stay low whatever the events do
  property p_off_a;
    @(posedge core_clk) disable iff (sys_rst)
      (routeEnable[5:3] == 3'h0) |=> !health_out_a;
  endproperty
  a_off_a: assert property (p_off_a) else $error("pin A high with no enables");

  // Pin A with only the selected-reference event copies the status bit
  property p_selref_on_a;
    @(posedge core_clk) disable iff (sys_rst)
      (routeEnable[5:3] == 3'h4) |=> (health_out_a == selRefStatus);
  endproperty
  a_selref_on_a: assert property (p_selref_on_a) else $error("pin A differs from reference flag");

  // Pin B with only the selected-reference event copies the status bit
  property p_selref_on_b;
    @(posedge core_clk) disable iff (sys_rst)
      (routeEnable[2:0] == 3'h4) |=> (health_out_b == selRefStatus);
  endproperty
  a_selref_on_b: assert property (p_selref_on_b) else $error("pin B differs from reference flag");

  // Pin A with only the loss event copies the loss flag
  property p_loss_on_a;
    @(posedge core_clk) disable iff (sys_rst)
      (routeEnable[5:3] == 3'h2) |=> (health_out_a == ref_loss_flag);
  endproperty
  a_loss_on_a: assert property (p_loss_on_a) else $error("pin A differs from loss flag");

  // Pin B with only the loss event copies the loss flag
  property p_loss_on_b;
    @(posedge core_clk) disable iff (sys_rst)
      (routeEnable[2:0] == 3'h2) |=> (health_out_b == ref_loss_flag);
  endproperty
  a_loss_on_b: assert property (p_loss_on_b) else $error("pin B differs from loss flag");

  // Pin A with only unlock shows the opposite of the unlock flag
  property p_unlock_on_a;
    @(posedge core_clk) disable iff (sys_rst)
      (routeEnable[5:3] == 3'h1) |=> (health_out_a != unlockStatus);
  endproperty
  a_unlock_on_a: assert property (p_unlock_on_a) else $error("pin A unlock sense wrong");

  // Pin B with only unlock shows the opposite of the unlock flag
  property p_unlock_on_b;
    @(posedge core_clk) disable iff (sys_rst)
      (routeEnable[2:0] == 3'h1) |=> (health_out_b != unlockStatus);
  endproperty
  a_unlock_on_b: assert property (p_unlock_on_b) else $error("pin B unlock sense wrong");

  // Reset clears pins and flags by the next edge
  property p_reset_quiet;
    @(posedge core_clk)
      sys_rst |=> !(health_out_a || health_out_b || selRefStatus || ref_loss_flag || unlockStatus);
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not cleared by reset");

  // Pin-mode secondary preset: code taken, table registered, status one edge on
  sequence s_pin_preset_sec;
    pinMode && presetCode == 5'h15 ##1 pinMode;
  endsequence
  property p_preset_sec;
    @(posedge core_clk) disable iff (sys_rst)
      s_pin_preset_sec |=> (selRefStatus == `SPM_REF_SECONDARY);
  endproperty
  a_preset_sec: assert property (p_preset_sec) else $error("preset 0x15 did not pick secondary");
endmodule
`default_nettype wire

// ===== tb/spm_board_watch.sv
`timescale 1ns/1ps
`default_nettype none
// Board logic that samples both status pins like a host GPIO port
module spm_board_watch (
  input  wire logic       core_clk,
  input  wire logic       pinA,
  input  wire logic       pinB,
  output var  logic [1:0] pinsSeen
);
  // One flop stage, so the bench waits an extra edge
  always_ff @(posedge core_clk) begin
    pinsSeen <= {pinA, pinB};
  end
endmodule
`default_nettype wire

// ===== tb/test_status_pin_mapper.sv
`timescale 1ns/1ps
`default_nettype none
module test_status_pin_mapper;
  import spm_pkg::*;
  logic        core_clk = 1'h0;
  logic        sys_rst = 1'h1;
  spm_route_t  routeEnable = 6'h00;
  spm_ifsel_t  interfaceSelect = 2'h0;
  spm_preset_t presetCode = 5'h00;
  logic        secondaryEnable = 1'h0, regRefSelect = 1'h0;
  logic        primaryPresent = 1'h0, secondaryPresent = 1'h0, pllLocked = 1'h0;
  logic        health_out_a, health_out_b, selRefStatus, ref_loss_flag, unlockStatus;
  logic [1:0]  pinsSeen;   // Pins as the board saw them
  logic        expSel, expLoss;
  int          fails = 0, check_count = 0, cycles = 0;
  // 100 MHz core clock
  always #5 core_clk = ~core_clk;
  spm_status_pin_mapper u_spm_status_pin_mapper (.core_clk(core_clk), .sys_rst(sys_rst),
    .routeEnable(routeEnable), .secondaryEnable(secondaryEnable), .interfaceSelect(interfaceSelect),
    .presetCode(presetCode), .regRefSelect(regRefSelect), .primaryPresent(primaryPresent),
    .secondaryPresent(secondaryPresent), .pllLocked(pllLocked), .health_out_a(health_out_a),
    .health_out_b(health_out_b), .selRefStatus(selRefStatus), .ref_loss_flag(ref_loss_flag),
    .unlockStatus(unlockStatus));
  spm_board_watch u_spm_board_watch (.core_clk(core_clk), .pinA(health_out_a), .pinB(health_out_b),
    .pinsSeen(pinsSeen));
  // Compare one status bit, unknowns never match
  task automatic check(input logic seen, input logic exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t status bit differs from expectation", $time);
    end
  endtask
  // All five observable bits; expSel and expLoss are set by the caller
  task automatic check_all;
    check(selRefStatus, expSel);
    check(ref_loss_flag, expLoss);
    check(unlockStatus, !pllLocked);
    // Pins show the lock level, the opposite of the unlock flag
    check(pinsSeen[1], |(routeEnable[5:3] & {expSel, expLoss, pllLocked}));
    check(pinsSeen[0], |(routeEnable[2:0] & {expSel, expLoss, pllLocked}));
  endtask
  // Single exit point for normal end and hang
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Sweep needs about 1600 cycles; ceiling leaves margin
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      complete_run;
    end
  end
  // Inputs change on falling edges only
  initial begin
    repeat (20) @(negedge core_clk);
    check(selRefStatus, 1'h0);
    check(ref_loss_flag, 1'h0);
    check(health_out_a | health_out_b | unlockStatus, 1'h0);
    sys_rst = 1'h0;
    $display("Reset test done");
    // Every route mask, event mix and preset code, pin mode on half the steps
    for (int i = 0; i < 512; i++) begin
      routeEnable = i[5:0];
      pllLocked = i[6];
      primaryPresent = i[7];
      secondaryPresent = i[8];
      secondaryEnable = (i % 5 != 0);
      regRefSelect = i[2] ^ i[7];
      interfaceSelect = i[1] ? 2'h2 : {1'h0, i[0]};
      presetCode = i[8:4];
      // Preset table and output register take two edges, board watcher one more
      repeat (3) @(negedge core_clk);
      expSel = i[1] ? !(presetCode inside {5'h14, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1F}) : regRefSelect;
      expLoss = !secondaryEnable || !(expSel ? secondaryPresent : primaryPresent);
      check_all;
    end
    $display("Routing sweep done");
    // Reset in mid-run: outputs clear, then recover with the last inputs
    sys_rst = 1'h1;
    repeat (2) @(negedge core_clk);
    check(health_out_a | health_out_b, 1'h0);
    check(selRefStatus | ref_loss_flag | unlockStatus, 1'h0);
    sys_rst = 1'h0;
    repeat (3) @(negedge core_clk);
    check_all;
    $display("Mid-run reset test done");
    complete_run;
  end
endmodule
`default_nettype wire
